//--- logic/mcu_decode_pkg.sv
// What this block does
// (RULE1) Each instruction arrives as one 14-bit word holding opcode and all operands.
// (RULE2) Opcodes fall into byte, bit, and literal/control groups.
// (RULE3) Instructions take one instruction cycle unless listed as multi-cycle.
// (RULE4) Direct call and call via working register take two cycles.
// (RULE5) Plain return, return with literal and interrupt return take two cycles.
// (RULE6) Jump, relative branch, working-register branch and taken skips take two cycles.
// (RULE7) Indirect access with pointer at program memory adds one cycle.
// (RULE8) One instruction cycle is exactly four oscillator clock periods.
// (RULE9) File-register instructions read, modify, then store, even write-only ones.
// (RULE10) Destination bit 0 sends result to working register, 1 to file.
// (RULE11) File address selects locations 0x00 through 0x7F.
// (RULE12) Bit number selects one bit of an 8-bit file register.
// (RULE13) Pointer number selects pointer or data port 0 or 1.
// (RULE14) Don't-care bit positions never change decoding.
// (RULE15) Pointer step mode picks pre/post increment or decrement.
// (RULE16) File address is the 7 low bits in byte and bit formats.
// (RULE17) Bit number is 3 bits directly above the file address.
// (RULE18) General literal instructions carry an 8-bit low immediate.
// (RULE19) Absolute call and jump carry an 11-bit target in bits 10:0.
// (RULE20) An unmet skip completes in one cycle and advances the counter once.
// (RULE21) Two-cycle instructions discard the fetched word and run a no-op.
`default_nettype none
package mcu_decode_pkg;

	// Timing of the instruction cycle.
	localparam int unsigned OSC_PER_ICYC = 4;
	localparam logic [1:0]  PH_Q1 = 2'h0;
	localparam logic [1:0]  PH_Q2 = 2'h1;
	localparam logic [1:0]  PH_Q3 = 2'h2;
	localparam logic [1:0]  PH_Q4 = 2'h3;

	// Word and field layout.
	localparam int unsigned WORD_W       = 14;
	localparam int unsigned FADDR_MSB    = 6;
	localparam int unsigned BITNUM_LSB   = 7;
	localparam int unsigned BITNUM_MSB   = 9;
	localparam int unsigned DEST_POS     = 7;
	localparam int unsigned LIT8_MSB     = 7;
	localparam int unsigned LIT11_MSB    = 10;
	localparam int unsigned LIT9_MSB     = 8;
	localparam int unsigned LIT7_MSB     = 6;
	localparam int unsigned LIT5_MSB     = 4;
	localparam int unsigned LIT6_MSB     = 5;
	localparam int unsigned OFS_PTR_POS  = 6;
	localparam int unsigned STEP_PTR_POS = 2;
	localparam int unsigned MODE_MSB     = 1;

	// File locations of the two indirect data ports.
	localparam logic [6:0] IND_PORT0 = 7'h00;
	localparam logic [6:0] IND_PORT1 = 7'h01;

	// Word executed after reset and in place of a discarded fetch.
	localparam logic [13:0] NOP_WORD = 14'h0000;

	// Fixed control words.
	localparam logic [13:0] W_RETURN = 14'h0008;
	localparam logic [13:0] W_RETFI  = 14'h0009;
	localparam logic [13:0] W_CALL_VIA_WORKING_REG  = 14'h000a;
	localparam logic [13:0] W_BRW    = 14'h000b;

	// Opcode patterns; a question mark is a don't-care or operand bit.
	localparam logic [13:0] P_STEP    = 14'b00_0000_0001_????;
	localparam logic [13:0] P_MOVLB   = 14'b00_0000_001?_????;
	localparam logic [13:0] P_CTRL    = 14'b00_0000_0???_????;
	localparam logic [13:0] P_DECSKP  = 14'b00_1011_????_????;
	localparam logic [13:0] P_INCSKP  = 14'b00_1111_????_????;
	localparam logic [13:0] P_BYTE    = 14'b00_????_????_????;
	localparam logic [13:0] P_BITCLR  = 14'b01_00??_????_????;
	localparam logic [13:0] P_BITSET  = 14'b01_01??_????_????;
	localparam logic [13:0] P_SKPCLR  = 14'b01_10??_????_????;
	localparam logic [13:0] P_SKPSET  = 14'b01_11??_????_????;
	localparam logic [13:0] P_CALL    = 14'b10_0???_????_????;
	localparam logic [13:0] P_GOTO    = 14'b10_1???_????_????;
	localparam logic [13:0] P_RETLIT  = 14'b11_0100_????_????;
	localparam logic [13:0] P_BRA     = 14'b11_001?_????_????;
	localparam logic [13:0] P_OFS     = 14'b11_0001_0???_????;
	localparam logic [13:0] P_MOVLP   = 14'b11_0001_1???_????;
	localparam logic [13:0] P_PTRMOV  = 14'b11_1111_????_????;
	localparam logic [13:0] P_BYTE_A  = 14'b11_0101_????_????;
	localparam logic [13:0] P_BYTE_B  = 14'b11_011?_????_????;
	localparam logic [13:0] P_BYTE_C  = 14'b11_1011_????_????;
	localparam logic [13:0] P_BYTE_D  = 14'b11_1101_????_????;

	typedef enum logic [1:0] {
		CLS_BYTE   = 2'b00,
		CLS_BIT    = 2'b01,
		CLS_LITCTL = 2'b10
	} instr_class_t;

	typedef enum logic [4:0] {
		K_NOP      = 5'b00000,
		K_CTRL     = 5'b00001,
		K_BYTE     = 5'b00010,
		K_BYTE_SKP = 5'b00011,
		K_BIT_CLR  = 5'b00100,
		K_BIT_SET  = 5'b00101,
		K_SKP_CLR  = 5'b00110,
		K_SKP_SET  = 5'b00111,
		K_LIT      = 5'b01000,
		K_RET_LIT  = 5'b01001,
		K_CALL     = 5'b01010,
		K_GOTO     = 5'b01011,
		K_REL_BR   = 5'b01100,
		K_RETURN   = 5'b01101,
		K_INT_RET  = 5'b01110,
		K_CALL_W   = 5'b01111,
		K_BR_W     = 5'b10000,
		K_PTR_STEP = 5'b10001,
		K_PTR_OFS  = 5'b10010,
		K_PTR_MOV  = 5'b10011,
		K_SEL_PAGE = 5'b10100,
		K_SEL_BANK = 5'b10101
	} instr_kind_t;

	typedef enum logic [1:0] {
		PRE_INC  = 2'b00,
		PRE_DEC  = 2'b01,
		POST_INC = 2'b10,
		POST_DEC = 2'b11
	} pointer_step_mode_t;

	typedef enum logic [1:0] {
		ST_EXEC  = 2'b00,
		ST_EXTRA = 2'b01,
		ST_FLUSH = 2'b10
	} cycle_state_t;

	typedef struct packed {
		logic        valid;
		logic [13:0] word;
	} fetch_t;

	typedef struct packed {
		instr_class_t       cls;
		instr_kind_t        kind;
		logic               dest_file;
		logic [6:0]         file_addr;
		logic [2:0]         bit_num;
		logic [7:0]         lit8;
		logic [10:0]        lit11;
		logic [8:0]         lit9;
		logic [6:0]         lit7;
		logic [4:0]         lit5;
		logic [5:0]         lit6;
		logic               ptr_num;
		pointer_step_mode_t pointer_step_mode;
		logic               uses_file;
		logic               writes_file;
		logic               indirect;
		logic               is_skip;
		logic               two_cycle;
		logic               redirect;
	} decoded_t;

	typedef struct packed {
		logic rd;
		logic wr_file;
		logic wr_w;
	} rmw_t;

endpackage
`default_nettype wire

//--- logic/mcu_quad_phase.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_quad_phase
	import mcu_decode_pkg::*;
#(
	parameter int unsigned PHASES = OSC_PER_ICYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	output var  logic [1:0] phase_reg
);

	logic [1:0] phase_next;

	// Four oscillator clocks make one instruction cycle.
	always_comb begin
		if (phase_reg == 2'(PHASES - 1)) begin
			phase_next = PH_Q1; // RULE8
		end else begin
			phase_next = phase_reg + 2'h1;
		end
	end

	// The phase counter wraps back to the first quarter.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= PH_Q1;
		end else begin
			phase_reg <= phase_next;
		end
	end

endmodule
`default_nettype wire

//--- logic/mcu_instruction_decode_timing.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_decode_timing
	import mcu_decode_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire mcu_decode_pkg::fetch_t   fetch,
	input  wire logic [1:0]               ptr_in_progmem,
	input  wire logic                     skip_cond,
	output var  mcu_decode_pkg::decoded_t dec_reg,
	output var  logic [1:0]               phase_reg,
	output var  mcu_decode_pkg::rmw_t     rmw_reg,
	output var  logic                     cycle_start_reg,
	output var  logic                     pc_inc_reg,
	output var  logic                     redirect_reg,
	output var  logic                     discard_reg,
	output var  logic                     extra_reg
);
	import mcu_decode_pkg::*;

	cycle_state_t state_reg;
	cycle_state_t state_next;
	logic         need_extra;
	logic         final_cycle;
	logic         branch_now;
	logic         cycle_end;
	decoded_t     fetched_dec;
	decoded_t     nop_dec;

	// Splits one 14-bit word into every operand the core may need.
	function automatic decoded_t decode(input logic [13:0] w);
		decoded_t d;
		d                   = '0;
		d.file_addr         = w[FADDR_MSB:0];            // RULE16 RULE11
		d.bit_num           = w[BITNUM_MSB:BITNUM_LSB];  // RULE17 RULE12
		d.dest_file         = w[DEST_POS];               // RULE10
		d.lit8              = w[LIT8_MSB:0];             // RULE18
		d.lit11             = w[LIT11_MSB:0];            // RULE19
		d.lit9              = w[LIT9_MSB:0];
		d.lit7              = w[LIT7_MSB:0];
		d.lit5              = w[LIT5_MSB:0];
		d.lit6              = w[LIT6_MSB:0];
		d.pointer_step_mode = pointer_step_mode_t'(w[MODE_MSB:0]); // RULE15
		d.ptr_num           = w[OFS_PTR_POS];
		d.cls               = CLS_LITCTL;
		d.kind              = K_LIT;
		// Patterns are tried from the most specific; unused bits are ignored.
		// The patterns overlap on purpose, so the first match must win.
		priority casez (w) // RULE1 RULE2 RULE14
			NOP_WORD: begin
				d.kind = K_NOP;
			end
			W_RETURN: begin
				d.kind = K_RETURN; // RULE5
			end
			W_RETFI: begin
				d.kind = K_INT_RET; // RULE5
			end
			W_CALL_VIA_WORKING_REG: begin
				d.kind = K_CALL_W; // RULE4
			end
			W_BRW: begin
				d.kind = K_BR_W; // RULE6
			end
			P_STEP: begin
				d.kind    = K_PTR_STEP;
				d.ptr_num = w[STEP_PTR_POS]; // RULE13
			end
			P_MOVLB: begin
				d.kind = K_SEL_BANK;
			end
			P_CTRL: begin
				d.kind = K_CTRL;
			end
			P_DECSKP, P_INCSKP: begin
				d.cls  = CLS_BYTE;
				d.kind = K_BYTE_SKP; // RULE6
			end
			P_BYTE, P_BYTE_A, P_BYTE_B, P_BYTE_C, P_BYTE_D: begin
				d.cls  = CLS_BYTE;
				d.kind = K_BYTE;
			end
			P_BITCLR: begin
				d.cls  = CLS_BIT;
				d.kind = K_BIT_CLR;
			end
			P_BITSET: begin
				d.cls  = CLS_BIT;
				d.kind = K_BIT_SET;
			end
			P_SKPCLR: begin
				d.cls  = CLS_BIT;
				d.kind = K_SKP_CLR; // RULE6
			end
			P_SKPSET: begin
				d.cls  = CLS_BIT;
				d.kind = K_SKP_SET; // RULE6
			end
			P_CALL: begin
				d.kind = K_CALL; // RULE4
			end
			P_GOTO: begin
				d.kind = K_GOTO; // RULE6
			end
			P_RETLIT: begin
				d.kind = K_RET_LIT; // RULE5
			end
			P_BRA: begin
				d.kind = K_REL_BR; // RULE6
			end
			P_OFS: begin
				d.kind = K_PTR_OFS;
			end
			P_MOVLP: begin
				d.kind = K_SEL_PAGE;
			end
			P_PTRMOV: begin
				d.kind = K_PTR_MOV;
			end
			default: begin
				d.kind = K_LIT;
			end
		endcase
		// File operands: both byte and bit groups read the register first.
		d.uses_file = (d.cls == CLS_BYTE) || (d.cls == CLS_BIT); // RULE9
		if (d.cls == CLS_BYTE) begin
			d.writes_file = d.dest_file; // RULE10
		end else begin
			d.writes_file = (d.kind == K_BIT_CLR) || (d.kind == K_BIT_SET);
		end
		// A file operand naming a data port goes through a pointer.
		if (d.uses_file && ((d.file_addr == IND_PORT0) ||
				(d.file_addr == IND_PORT1))) begin
			d.indirect = 1'b1;
			d.ptr_num  = d.file_addr[0]; // RULE13
		end else begin
			d.indirect = (d.kind == K_PTR_STEP) || (d.kind == K_PTR_MOV);
		end
		d.is_skip  = (d.kind == K_BYTE_SKP) || (d.kind == K_SKP_CLR) ||
			(d.kind == K_SKP_SET);
		d.redirect = (d.kind == K_CALL) || (d.kind == K_CALL_W) ||
			(d.kind == K_RETURN) || (d.kind == K_RET_LIT) ||
			(d.kind == K_INT_RET) || (d.kind == K_GOTO) ||
			(d.kind == K_REL_BR) || (d.kind == K_BR_W);
		d.two_cycle = d.redirect || d.is_skip; // RULE3 RULE4 RULE5 RULE6
		return d;
	endfunction

	// Phase counter shared by every timing decision.
	mcu_quad_phase #(
		.PHASES (OSC_PER_ICYC)
	) u_phase (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.phase_reg (phase_reg)
	);

	// Decodes of the incoming word and of the no-op used in its place.
	assign fetched_dec = decode(fetch.valid ? fetch.word : NOP_WORD);
	assign nop_dec     = decode(NOP_WORD);
	assign cycle_end   = (phase_reg == PH_Q4);

	// Extra cycle when the chosen pointer reaches into program memory.
	assign need_extra  = (state_reg == ST_EXEC) && dec_reg.indirect &&
		ptr_in_progmem[dec_reg.ptr_num]; // RULE7
	assign final_cycle = ((state_reg == ST_EXEC) && !need_extra) ||
		(state_reg == ST_EXTRA);
	// A skip only branches when its condition holds.
	assign branch_now  = dec_reg.two_cycle &&
		(!dec_reg.is_skip || skip_cond); // RULE20

	// Sequencing of execute, extra and discard cycles.
	always_comb begin
		unique case (state_reg)
			ST_EXEC: begin
				if (need_extra) begin
					state_next = ST_EXTRA; // RULE7
				end else if (branch_now) begin
					state_next = ST_FLUSH; // RULE21
				end else begin
					state_next = ST_EXEC; // RULE3
				end
			end
			ST_EXTRA: begin
				state_next = branch_now ? ST_FLUSH : ST_EXEC;
			end
			ST_FLUSH: begin
				state_next = ST_EXEC;
			end
			default: begin
				state_next = ST_EXEC;
			end
		endcase
	end

	// The state moves only at the end of an instruction cycle.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_FLUSH;
		end else if (cycle_end) begin
			state_reg <= state_next; // RULE8
		end
	end

	// Instruction register: a new word, a no-op, or the held instruction.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dec_reg <= '0;
		end else if (cycle_end) begin
			if (state_next == ST_EXEC) begin
				dec_reg <= fetched_dec; // RULE1
			end else if (state_next == ST_FLUSH) begin
				dec_reg <= nop_dec; // RULE21
			end
		end
	end

	// Read in the second quarter, store in the fourth of the last cycle.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rmw_reg <= '0;
		end else begin
			rmw_reg.rd      <= (phase_reg == PH_Q1) &&
				(state_reg == ST_EXEC) && dec_reg.uses_file; // RULE9
			rmw_reg.wr_file <= (phase_reg == PH_Q3) && final_cycle &&
				dec_reg.writes_file; // RULE9 RULE10
			rmw_reg.wr_w    <= (phase_reg == PH_Q3) && final_cycle &&
				(dec_reg.cls == CLS_BYTE) && !dec_reg.dest_file; // RULE10
		end
	end

	// Program counter strobes raised in the first quarter of the next cycle.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pc_inc_reg   <= 1'b0;
			redirect_reg <= 1'b0;
		end else begin
			pc_inc_reg   <= cycle_end && ((state_reg == ST_FLUSH) ||
				(final_cycle && !(branch_now && dec_reg.redirect))); // RULE20
			redirect_reg <= cycle_end && final_cycle && branch_now &&
				dec_reg.redirect; // RULE6
		end
	end

	// Status levels that follow the cycle being entered.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cycle_start_reg <= 1'b0;
			discard_reg     <= 1'b1;
			extra_reg       <= 1'b0;
		end else begin
			cycle_start_reg <= cycle_end; // RULE8
			if (cycle_end) begin
				discard_reg <= (state_next == ST_FLUSH); // RULE21
				extra_reg   <= (state_next == ST_EXTRA); // RULE7
			end
		end
	end

endmodule
`default_nettype wire

//--- test/prog_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model
	import mcu_decode_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   pc_inc,
	output var  mcu_decode_pkg::fetch_t fetch
);
	logic [13:0] mem [0:63];
	logic [5:0]  pc_reg;

	// The counter only steps forward; branch targets are not followed.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pc_reg <= 6'h00;
		end else if (pc_inc) begin
			pc_reg <= pc_reg + 6'h01;
		end
	end

	// Each word is presented whole, opcode and operands together.
	always_comb begin
		fetch.valid = 1'b1;
		fetch.word = mem[pc_reg];
	end
endmodule
`default_nettype wire

//--- test/decode_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module decode_checker
	import mcu_decode_pkg::*;
(
	input wire logic                     sys_clk,
	input wire logic                     rst,
	input wire mcu_decode_pkg::fetch_t   fetch,
	input wire logic [1:0]               ptr_in_progmem,
	input wire logic                     skip_cond,
	input wire mcu_decode_pkg::decoded_t dec_reg,
	input wire logic [1:0]               phase_reg,
	input wire mcu_decode_pkg::rmw_t     rmw_reg,
	input wire logic                     cycle_start_reg,
	input wire logic                     pc_inc_reg,
	input wire logic                     redirect_reg,
	input wire logic                     discard_reg,
	input wire logic                     extra_reg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// First quarter of the first cycle of a fresh instruction.
	sequence s_start;
		cycle_start_reg && !discard_reg && !extra_reg;
	endsequence

	// A skip without an extra cycle, seen up to its last quarter.
	sequence s_skip_end;
		s_start ##0 (dec_reg.is_skip && !dec_reg.indirect) ##3 1'b1;
	endsequence

	chk_cycle_four: assert property (cycle_start_reg |=> !cycle_start_reg [*3] ##1 cycle_start_reg) else $error("cycle length wrong");
	chk_start_phase: assert property (cycle_start_reg |-> phase_reg == 2'h0) else $error("cycle start off phase");
	chk_dec_hold: assert property (!$stable(dec_reg) |-> phase_reg == 2'h0) else $error("decode changed mid cycle");
	chk_read_always: assert property (s_start ##0 dec_reg.uses_file |=> rmw_reg.rd) else $error("file read missing");
	chk_read_place: assert property (rmw_reg.rd |-> phase_reg == 2'h1 && dec_reg.uses_file) else $error("stray file read");
	chk_w_dest: assert property (rmw_reg.wr_w |-> phase_reg == 2'h3 && !dec_reg.dest_file) else $error("bad W store");
	chk_file_dest: assert property (rmw_reg.wr_file |-> phase_reg == 2'h3 && (dec_reg.dest_file || dec_reg.cls == CLS_BIT)) else $error("bad file store");
	chk_branch_flush: assert property (s_start ##0 (dec_reg.redirect && !dec_reg.indirect) |-> ##4 (discard_reg && redirect_reg)) else $error("branch not flushed");
	chk_skip_miss: assert property (s_skip_end ##0 !skip_cond |=> !discard_reg && pc_inc_reg) else $error("unmet skip wrong");
	chk_skip_hit: assert property (s_skip_end ##0 skip_cond |=> discard_reg && pc_inc_reg) else $error("taken skip wrong");
	chk_extra_cycle: assert property (s_start ##0 dec_reg.indirect ##3 ptr_in_progmem[dec_reg.ptr_num] |=> extra_reg) else $error("extra cycle missing");
	chk_nop_quiet: assert property (discard_reg |-> rmw_reg == 3'h0) else $error("discard cycle not idle");
endmodule

bind mcu_instruction_decode_timing decode_checker decode_checker_inst (
	.sys_clk(sys_clk), .rst(rst), .fetch(fetch),
	.ptr_in_progmem(ptr_in_progmem), .skip_cond(skip_cond),
	.dec_reg(dec_reg), .phase_reg(phase_reg), .rmw_reg(rmw_reg),
	.cycle_start_reg(cycle_start_reg), .pc_inc_reg(pc_inc_reg),
	.redirect_reg(redirect_reg), .discard_reg(discard_reg),
	.extra_reg(extra_reg)
);
`default_nettype wire

//--- test/mcu_instruction_decode_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_instruction_decode_timing_tb;
	import mcu_decode_pkg::*;
	logic sys_clk, rst, skip_cond, cycle_start_reg, pc_inc_reg;
	logic redirect_reg, discard_reg, extra_reg;
	logic [1:0] ptr_in_progmem, phase_reg;
	fetch_t fetch;
	decoded_t dec_reg;
	rmw_t rmw_reg;
	int n_errors, n_compared;
	logic [31:0] seed, r;
	logic [13:0] prog [0:63];
	logic [13:0] w;
	int idx, cnt, exp_cyc;
	// Fixed words: control, returns, branches, pointer steps, skips.
	logic [13:0] hand [0:19] = '{14'h0008, 14'h0009, 14'h000a, 14'h000b,
		14'h3455, 14'h3301, 14'h0010, 14'h0011, 14'h0012, 14'h0013,
		14'h0014, 14'h0015, 14'h0016, 14'h0017, 14'h0b81, 14'h0f20,
		14'h1800, 14'h1c01, 14'h2fff, 14'h3f40};

	mcu_instruction_decode_timing mcu_instruction_decode_timing_inst (
		.sys_clk(sys_clk), .rst(rst), .fetch(fetch),
		.ptr_in_progmem(ptr_in_progmem), .skip_cond(skip_cond),
		.dec_reg(dec_reg), .phase_reg(phase_reg), .rmw_reg(rmw_reg),
		.cycle_start_reg(cycle_start_reg), .pc_inc_reg(pc_inc_reg),
		.redirect_reg(redirect_reg), .discard_reg(discard_reg),
		.extra_reg(extra_reg));
	prog_mem_model prog_mem_model_inst (.sys_clk(sys_clk), .rst(rst),
		.pc_inc(pc_inc_reg), .fetch(fetch));

	// Clock of 100 ns.
	always #50 sys_clk = ~sys_clk;

	// Next xorshift value.
	task automatic rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		r = seed;
	endtask

	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done();
		$display("counts: %0d compared, %0d wrong", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Group an encoding falls into.
	function automatic instr_class_t e_cls(input logic [13:0] v);
		if (v[13:12] == 2'b01) return CLS_BIT;
		if (v[13:12] == 2'b00 && v[13:7] != 7'h00) return CLS_BYTE;
		return CLS_LITCTL;
	endfunction

	// Skip instructions of both the byte and the bit group.
	function automatic logic e_skip(input logic [13:0] v);
		return v[13:8] == 6'h0b || v[13:8] == 6'h0f || v[13:11] == 3'b011;
	endfunction

	// Cycles taken for a word under the given pointer and skip inputs.
	function automatic int e_cycles(input logic [13:0] v,
		input logic [1:0] p, input logic s);
		logic two, ind, n;
		two = v[13:12] == 2'b10 || v[13:2] == 12'h002 ||
			v[13:8] == 6'h34 || v[13:9] == 5'h19;
		ind = 1'b0;
		n = 1'b0;
		if (e_cls(v) != CLS_LITCTL && v[6:1] == 6'h00) {ind, n} = {1'b1, v[0]};
		if (v[13:4] == 10'h001) {ind, n} = {1'b1, v[2]};
		if (v[13:8] == 6'h3f) {ind, n} = {1'b1, v[6]};
		return 1 + int'(two) + int'(e_skip(v) & s) + int'(ind & p[n]);
	endfunction

	initial begin
		#200000;
		n_errors++;
		test_done();
	end

	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		ptr_in_progmem = 2'h0;
		skip_cond = 1'b0;
		n_errors = 0;
		n_compared = 0;
		seed = 32'h000061e3;
		// Hand words first, then random words of every group.
		for (int i = 0; i < 64; i++) begin
			rnd();
			case (r[1:0])
				2'h0: w = {2'b00, (r[5:2] == 4'h0) ? 4'h7 : r[5:2], r[13:6]};
				2'h1: w = {2'b01, r[13:2]};
				2'h2: w = {2'b11, 1'b1, r[2], 1'b0, r[3] & ~r[2], r[11:4]};
				default: w = {2'b10, r[13:2]};
			endcase
			if (r[20] && r[1] == 1'b0) w[6:1] = 6'h00;
			prog[i] = (i < 20) ? hand[i] : w;
			prog_mem_model_inst.mem[i] = prog[i];
		end
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		idx = 0;
		exp_cyc = 0;
		for (int k = 0; idx < 60; k++) begin
			cnt = 0;
			do begin
				@(posedge sys_clk);
				if (cycle_start_reg === 1'b1) cnt++;
			end while (!(cycle_start_reg && !discard_reg && !extra_reg) && cnt < 9);
			if (k > 0) check(32'(cnt), 32'(exp_cyc));
			w = prog[idx];
			check(32'(dec_reg.cls), 32'(e_cls(w)));
			if (e_cls(w) != CLS_LITCTL) begin
				check(32'(dec_reg.file_addr), 32'(w[6:0]));
				check(32'(dec_reg.uses_file), 32'h1);
			end
			if (e_cls(w) == CLS_BYTE) check(32'(dec_reg.dest_file), 32'(w[7]));
			if (e_cls(w) == CLS_BIT) check(32'(dec_reg.bit_num), 32'(w[9:7]));
			if (w[13:12] == 2'b10) check(32'(dec_reg.lit11), 32'(w[10:0]));
			if (w[13:12] == 2'b11 && (w[11] || w[11:8] == 4'h4)) begin
				if (w[11:8] != 4'hf) check(32'(dec_reg.lit8), 32'(w[7:0]));
			end
			if (w[13:9] == 5'h19) check(32'(dec_reg.lit9), 32'(w[8:0]));
			if (w[13:7] == 7'h63) check(32'(dec_reg.lit7), 32'(w[6:0]));
			if (w[13:7] == 7'h62) check(32'(dec_reg.lit6), 32'(w[5:0]));
			if (w[13:5] == 9'h001) check(32'(dec_reg.lit5), 32'(w[4:0]));
			if (w[13:4] == 10'h001) begin
				check(32'(dec_reg.pointer_step_mode), 32'(w[1:0]));
				check(32'(dec_reg.ptr_num), 32'(w[2]));
			end
			rnd();
			ptr_in_progmem <= r[1:0];
			skip_cond <= r[2];
			exp_cyc = e_cycles(w, r[1:0], r[2]);
			idx = idx + 1 + int'(e_skip(w) & r[2]);
		end
		$display("decode stream test done");
		// Reset in mid-run returns to the discard state.
		rst <= 1'b1;
		@(posedge sys_clk);
		@(negedge sys_clk);
		check(32'(discard_reg), 32'h1);
		check(32'(dec_reg.kind), 32'(K_NOP));
		@(posedge sys_clk);
		rst <= 1'b0;
		// The discard cycle after release ends at the fourth edge.
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		check(32'(cycle_start_reg), 32'h1);
		check(32'(discard_reg), 32'h0);
		check(32'(dec_reg.kind), 32'(K_RETURN));
		repeat (8) @(posedge sys_clk);
		$display("reset test done");
		test_done();
	end
endmodule
`default_nettype wire
